/* rtl/fpc_top.sv */
// fieldbus startup parametrization, control byte decode and status byte build
`timescale 1ns/1ps
`default_nettype none
module fpc_top (
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // bus session
    input wire logic bus_start,
    input wire logic startup_done,
    output logic in_startup,
    // startup parameter writes from the master
    input wire logic param_valid,
    input wire logic [fpc_pkg::INDEX_W-1:0] param_index,
    input wire logic param_slot,
    input wire logic [fpc_pkg::VALUE_W-1:0] param_value,
    // parameter response channel
    output logic resp_valid,
    output logic [fpc_pkg::INDEX_W-1:0] resp_index,
    output logic [fpc_pkg::CODE_W-1:0] resp_code,
    output logic param_rejected,
    // local programming interface
    input wire logic local_wr,
    input wire logic [fpc_pkg::INDEX_W-1:0] local_index,
    input wire logic local_slot,
    input wire logic [fpc_pkg::VALUE_W-1:0] local_value,
    // parameter readback
    input wire logic [fpc_pkg::INDEX_W-1:0] cfg_index,
    input wire logic cfg_slot,
    output logic [fpc_pkg::VALUE_W-1:0] cfg_value,
    // cyclic control byte and its decoded controls
    input wire logic [7:0] host_command_byte,
    output logic standby,
    output logic measure_direction,
    output logic trigger_one,
    output logic trigger_two,
    output logic error_clear,
    output logic restore_start,
    output logic [1:0] restore_set,
    // measurement state
    input wire logic error_detected,
    input wire logic signal_acquired,
    input wire logic [fpc_pkg::VALUE_W-1:0] speed_value,
    input wire logic [fpc_pkg::VALUE_W-1:0] length_value,
    // cyclic status
    output logic [7:0] sensor_status_byte,
    output logic status_byte_valid,
    output logic [fpc_pkg::VALUE_W-1:0] velocity_magnitude,
    output logic [fpc_pkg::VALUE_W-1:0] length_magnitude
);
    import fpc_pkg::*;

    fpc_phase_type phase_q;
    fpc_phase_type phase_d;
    logic [31:0] store_q [ENTRY_COUNT];
    logic resp_valid_q;
    logic [5:0] resp_index_q;
    logic [15:0] resp_code_q;
    logic rejected_q;
    logic [31:0] cfg_value_q;
    logic [7:0] cmd_prev_q;
    logic standby_q;
    logic direction_q;
    logic trigger_one_q;
    logic trigger_two_q;
    logic error_clear_q;
    logic restore_start_q;
    logic [1:0] restore_set_q;
    logic [7:0] status_q;
    logic status_valid_q;
    logic [31:0] velocity_q;
    logic [31:0] length_q;
    logic chk_ok;
    logic [15:0] chk_code;

    // one checker serves the master during startup and the local port otherwise
    wire sel_startup = (phase_q != FPC_RUN);
    wire chk_valid = sel_startup ? (phase_q == FPC_STARTUP && param_valid) : local_wr;
    wire [5:0] chk_index = sel_startup ? param_index : local_index;
    wire chk_slot = sel_startup ? param_slot : local_slot;
    wire [31:0] chk_value = sel_startup ? param_value : local_value;

    fpc_param_check u_check (
        .index(chk_index),
        .slot(chk_slot),
        .value(chk_value),
        .ok(chk_ok),
        .code(chk_code)
    );

    wire store_wr = chk_valid && chk_ok && !bus_start;
    wire reject = chk_valid && !chk_ok && (phase_q == FPC_STARTUP) && !bus_start;
    wire [6:0] store_sel = {chk_index - 6'h01, chk_slot};
    wire [6:0] cfg_sel = {cfg_index - 6'h01, cfg_slot};
    wire seltrigger = store_q[ENT_SELTRIGGER][0];
    wire layout_status = (store_q[ENT_LAYOUT] == LAYOUT_STATUS);

    // control byte decode
    wire clear_edge = host_command_byte[CMD_CLEAR] && !cmd_prev_q[CMD_CLEAR];
    wire restore_edge = host_command_byte[CMD_RESTORE] && !cmd_prev_q[CMD_RESTORE];
    wire standby_src = seltrigger ? host_command_byte[CMD_STANDBY_ALT] : host_command_byte[CMD_STANDBY];
    wire trigger_two_src = seltrigger && host_command_byte[CMD_STANDBY];
    wire speed_neg = speed_value[31];
    wire length_neg = length_value[31];
    wire [31:0] speed_abs = speed_neg ? 32'h0000_0000 - speed_value : speed_value;
    wire [31:0] length_abs = length_neg ? 32'h0000_0000 - length_value : length_value;
    wire [7:0] status_src = {4'h0, length_neg, speed_neg, signal_acquired, error_detected};

    // startup phase sequencing
    always_comb begin
        phase_d = phase_q;
        if (bus_start) begin
            phase_d = FPC_STARTUP;
        end else begin
            unique case (phase_q)
                FPC_RUN: phase_d = FPC_RUN;
                FPC_STARTUP: begin
                    if (startup_done) phase_d = FPC_RUN;
                    else if (reject) phase_d = FPC_REJECT;
                end
                FPC_REJECT: begin
                    if (startup_done) phase_d = FPC_RUN;
                end
                default: phase_d = FPC_RUN;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) phase_q <= FPC_RUN;
        else phase_q <= phase_d;
    end

    // parameter store, reloaded with defaults at every bus start
    for (genvar e = 0; e < ENTRY_COUNT; e++) begin : g_entry
        always_ff @(posedge sys_clk) begin
            if (reset || bus_start) store_q[e] <= fpc_param_default(6'(e / 2 + 1), 1'(e % 2));
            else if (store_wr && store_sel == 7'(e)) store_q[e] <= chk_value;
        end
    end

    // error response, index and code together in one cycle
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            resp_valid_q <= 1'b0;
            resp_index_q <= 6'h00;
            resp_code_q <= 16'h0000;
        end else begin
            resp_valid_q <= reject;
            if (reject) begin
                resp_index_q <= chk_index;
                resp_code_q <= chk_code;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset || bus_start) rejected_q <= 1'b0;
        else if (reject) rejected_q <= 1'b1;
    end

    always_ff @(posedge sys_clk) begin
        if (reset) cfg_value_q <= 32'h0000_0000;
        else cfg_value_q <= (cfg_index == 6'h00 || cfg_index > IDX_LAST) ? 32'h0000_0000 : store_q[cfg_sel];
    end

    // control outputs
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            cmd_prev_q <= 8'h00;
            standby_q <= 1'b0;
            direction_q <= 1'b0;
            trigger_one_q <= 1'b0;
            trigger_two_q <= 1'b0;
        end else begin
            cmd_prev_q <= host_command_byte;
            standby_q <= standby_src;
            direction_q <= host_command_byte[CMD_DIRECTION];
            trigger_one_q <= host_command_byte[CMD_TRIGGER_ONE];
            trigger_two_q <= trigger_two_src;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            error_clear_q <= 1'b0;
            restore_start_q <= 1'b0;
            restore_set_q <= 2'h0;
        end else begin
            error_clear_q <= clear_edge;
            restore_start_q <= restore_edge;
            if (restore_edge) restore_set_q <= host_command_byte[CMD_SET_HI:CMD_SET_LO];
        end
    end

    // status byte and unsigned magnitudes
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            status_q <= 8'h00;
            status_valid_q <= 1'b0;
            velocity_q <= 32'h0000_0000;
            length_q <= 32'h0000_0000;
        end else begin
            status_q <= status_src;
            status_valid_q <= layout_status;
            velocity_q <= speed_abs;
            length_q <= length_abs;
        end
    end

    assign in_startup = sel_startup;
    assign resp_valid = resp_valid_q;
    assign resp_index = resp_index_q;
    assign resp_code = resp_code_q;
    assign param_rejected = rejected_q;
    assign cfg_value = cfg_value_q;
    assign standby = standby_q;
    assign measure_direction = direction_q;
    assign trigger_one = trigger_one_q;
    assign trigger_two = trigger_two_q;
    assign error_clear = error_clear_q;
    assign restore_start = restore_start_q;
    assign restore_set = restore_set_q;
    assign sensor_status_byte = status_q;
    assign status_byte_valid = status_valid_q;
    assign velocity_magnitude = velocity_q;
    assign length_magnitude = length_q;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    sequence s_reject_seen;
        (phase_q == FPC_STARTUP) && param_valid && !bus_start && !chk_ok;
    endsequence

    sequence s_response_given(logic [5:0] idx);
        resp_valid && resp_index == idx ##1 !resp_valid;
    endsequence

    a_reject_response: assert property (
        s_reject_seen |=> s_response_given($past(param_index)))
        else $error("rejected parameter not reported with its index");

    a_reject_discard: assert property (
        s_reject_seen ##1 (phase_q == FPC_REJECT && !bus_start && param_valid) |-> !store_wr)
        else $error("parameter applied after a rejection");

    a_response_in_startup: assert property (
        resp_valid |-> $past(phase_q) == FPC_STARTUP)
        else $error("parameter response outside startup phase");

    a_master_ignored_run: assert property (
        (phase_q == FPC_RUN && !bus_start) |=> !resp_valid)
        else $error("master write handled outside startup");

    a_start_defaults: assert property (
        bus_start |=> (store_q[ENT_AVERAGE] == AVERAGE_DEF) && phase_q == FPC_STARTUP && !param_rejected)
        else $error("bus start did not restore defaults");

    a_accel_range: assert property (
        (chk_valid && chk_index == IDX_ACCEL && chk_value > ACCEL_HI) |-> !chk_ok && chk_code == ERR_RANGE)
        else $error("acceleration above limit accepted");

    a_react_range: assert property (
        (chk_valid && chk_index == IDX_HOLD && chk_slot) |-> chk_ok == (chk_value >= REACT_LO && chk_value <= REACT_HI))
        else $error("reaction time limits wrong");

    a_clear_edge: assert property (
        $rose(host_command_byte[CMD_CLEAR]) |=> error_clear ##1 (!error_clear || $rose(host_command_byte[CMD_CLEAR])))
        else $error("clear edge not turned into one pulse");

    a_clear_level: assert property (
        (host_command_byte[CMD_CLEAR] && $past(host_command_byte[CMD_CLEAR])) |=> !error_clear)
        else $error("steady clear level produced a pulse");

    a_restore_once: assert property (
        (host_command_byte[CMD_RESTORE] [*3]) |=> !restore_start)
        else $error("restore repeated while bit held");

    a_restore_set: assert property (
        $rose(host_command_byte[CMD_RESTORE]) |=> restore_start && restore_set == $past(host_command_byte[6:5]))
        else $error("restore set number not taken");

    a_standby_source: assert property (
        1'b1 |=> standby == $past(seltrigger ? host_command_byte[0] : host_command_byte[2]))
        else $error("standby taken from wrong control bit");

    a_trigger_two: assert property (
        (!seltrigger && host_command_byte[CMD_STANDBY]) |=> !trigger_two)
        else $error("trigger two active while bit 2 means standby");

    a_status_layout: assert property (
        ##1 sensor_status_byte[7:4] == 4'h0 && sensor_status_byte[STAT_SPEED_NEG] == $past(speed_value[31]))
        else $error("status byte reserved bits or speed sign wrong");

    a_velocity_sign: assert property (
        ($past(speed_value) == 32'hffff_ffff) |-> velocity_magnitude == 32'h0000_0001)
        else $error("velocity not sent as magnitude");

endmodule : fpc_top
`default_nettype wire

/* rtl/fpc_pkg.sv */
// constants, types and parameter table of the fieldbus parameter and control block
//
// Contract
// - parameters accepted only in startup after bus start
// - bus start values overwrite local settings
// - fractions travel as step-scaled integers
// - after first rejection, discard rest of sequence
// - error reported as parameter index plus code
// - acceleration 0 to 100 tenths, default 20
// - averaging time 0 to 65535, default 20
// - hold 10..65535 def 250; reaction 9..65564 def 10
// - offset, thresholds 0..9999999; switches default off
// - vmax 1..10000; vmin 0..1000000 default 0
// - pulse outputs: sign, scale, enable, sync defaults
// - mode 6 status byte: error, signal, signs
// - standby from bit 2, or bit 0 if selected
// - bit 1 level sets measuring direction
// - bit 3 level is trigger one
// - bit 2 is standby or trigger two
// - rising bit 4 clears error list
// - bits 6:5 select set, bit 7 restores
// - velocity unsigned, sign in status byte
package fpc_pkg;
    localparam int VALUE_W = 32;
    localparam int INDEX_W = 6;
    localparam int CODE_W = 16;
    localparam int PARAM_COUNT = 36;
    localparam int ENTRY_COUNT = 2 * PARAM_COUNT;
    localparam int ENTRY_W = 7;

    // parameter numbers
    localparam logic [5:0] IDX_ACCEL = 6'h01;
    localparam logic [5:0] IDX_AVERAGE = 6'h02;
    localparam logic [5:0] IDX_DIRECTION = 6'h04;
    localparam logic [5:0] IDX_HOLD = 6'h05;
    localparam logic [5:0] IDX_OFFSET = 6'h06;
    localparam logic [5:0] IDX_MINRATE = 6'h07;
    localparam logic [5:0] IDX_SELTRIGGER = 6'h09;
    localparam logic [5:0] IDX_TRACKING = 6'h0a;
    localparam logic [5:0] IDX_TRIGGER = 6'h0b;
    localparam logic [5:0] IDX_VMAX = 6'h0c;
    localparam logic [5:0] IDX_VMIN = 6'h0d;
    localparam logic [5:0] IDX_WINDOW = 6'h0e;
    localparam logic [5:0] IDX_PULSE_A = 6'h0f;
    localparam logic [5:0] IDX_PULSE_B = 6'h12;
    localparam logic [5:0] IDX_PULSE_C = 6'h15;
    localparam logic [5:0] IDX_LAYOUT = 6'h18;
    localparam logic [5:0] IDX_PERIOD = 6'h19;
    localparam logic [5:0] IDX_THRESH_1 = 6'h1b;
    localparam logic [5:0] IDX_THRESH_8 = 6'h22;
    localparam logic [5:0] IDX_LAST = 6'h24;

    // store entries read by the block's own logic and its assertions
    localparam logic [6:0] ENT_SELTRIGGER = 7'h10;
    localparam logic [6:0] ENT_LAYOUT = 7'h2e;
    localparam logic [6:0] ENT_AVERAGE = 7'h02;

    // limits and defaults, scaled by step size
    localparam logic [31:0] ACCEL_HI = 32'h0000_0064;
    localparam logic [31:0] ACCEL_DEF = 32'h0000_0014;
    localparam logic [31:0] U16_HI = 32'h0000_ffff;
    localparam logic [31:0] AVERAGE_DEF = 32'h0000_0014;
    localparam logic [31:0] HOLD_LO = 32'h0000_000a;
    localparam logic [31:0] HOLD_DEF = 32'h0000_00fa;
    localparam logic [31:0] REACT_LO = 32'h0000_0009;
    localparam logic [31:0] REACT_HI = 32'h0001_001c;
    localparam logic [31:0] REACT_DEF = 32'h0000_000a;
    localparam logic [31:0] LENGTH_HI = 32'h0098_967f;
    localparam logic [31:0] SEL4_HI = 32'h0000_0004;
    localparam logic [31:0] SEL5_HI = 32'h0000_0005;
    localparam logic [31:0] SEL_DEF2 = 32'h0000_0002;
    localparam logic [31:0] MINRATE_HI = 32'h0000_0063;
    localparam logic [31:0] VMAX_HI = 32'h0000_2710;
    localparam logic [31:0] VMAX_DEF = 32'h0000_0190;
    localparam logic [31:0] VMIN_HI = 32'h000f_4240;
    localparam logic [31:0] WINDOW_HI = 32'h0000_0020;
    localparam logic [31:0] WINDOW_DEF = 32'h0000_0008;
    localparam logic [31:0] SCALE_HI = 32'h0000_61a8;
    localparam logic [31:0] SCALE_DEF = 32'h0000_000a;
    localparam logic [31:0] LAYOUT_HI = 32'h0000_0006;
    localparam logic [31:0] PERIOD_DEF = 32'h0000_001e;
    localparam logic [31:0] ONE = 32'h0000_0001;
    localparam logic [31:0] ZERO = 32'h0000_0000;
    localparam logic [31:0] LAYOUT_STATUS = 32'h0000_0006;

    // response codes, four decimal digits
    localparam logic [15:0] ERR_UNKNOWN = 16'h0001;
    localparam logic [15:0] ERR_RANGE = 16'h0004;

    // control byte bits
    localparam int CMD_STANDBY_ALT = 0;
    localparam int CMD_DIRECTION = 1;
    localparam int CMD_STANDBY = 2;
    localparam int CMD_TRIGGER_ONE = 3;
    localparam int CMD_CLEAR = 4;
    localparam int CMD_SET_LO = 5;
    localparam int CMD_SET_HI = 6;
    localparam int CMD_RESTORE = 7;

    // status byte bits
    localparam int STAT_ERROR = 0;
    localparam int STAT_SIGNAL = 1;
    localparam int STAT_SPEED_NEG = 2;
    localparam int STAT_LENGTH_NEG = 3;

    typedef enum logic [1:0] {
        FPC_RUN = 2'b00,
        FPC_STARTUP = 2'b01,
        FPC_REJECT = 2'b10
    } fpc_phase_type;

    function automatic logic [31:0] fpc_param_default(input logic [5:0] index, input logic slot);
        logic [31:0] v;
        v = ZERO;
        if (index == IDX_ACCEL) v = ACCEL_DEF;
        else if (index == IDX_AVERAGE) v = AVERAGE_DEF;
        else if (index == IDX_DIRECTION || index == IDX_TRACKING) v = SEL_DEF2;
        else if (index == IDX_HOLD) v = slot ? REACT_DEF : HOLD_DEF;
        else if (index == IDX_VMAX) v = VMAX_DEF;
        else if (index == IDX_WINDOW) v = WINDOW_DEF;
        else if ((index == IDX_PULSE_A || index == IDX_PULSE_B || index == IDX_PULSE_C) && slot) v = SCALE_DEF;
        else if (index == IDX_LAYOUT) v = LAYOUT_STATUS;
        else if (index == IDX_PERIOD) v = PERIOD_DEF;
        return v;
    endfunction : fpc_param_default
endpackage : fpc_pkg

/* rtl/fpc_param_check.sv */
// range check of one parameter value against its number and slot
`timescale 1ns/1ps
`default_nettype none
module fpc_param_check (
    // candidate value
    input wire logic [fpc_pkg::INDEX_W-1:0] index,
    input wire logic slot,
    input wire logic [fpc_pkg::VALUE_W-1:0] value,
    // verdict
    output logic ok,
    output logic [fpc_pkg::CODE_W-1:0] code
);
    import fpc_pkg::*;

    logic [31:0] lo;
    logic [31:0] hi;
    logic known;
    logic two_slot;
    wire pulse_sign = (index == IDX_PULSE_A || index == IDX_PULSE_B || index == IDX_PULSE_C);

    always_comb begin
        lo = ZERO;
        hi = ONE;
        known = 1'b1;
        two_slot = 1'b0;
        if (index == IDX_ACCEL) begin
            hi = ACCEL_HI;
        end else if (index == IDX_AVERAGE || index == IDX_PERIOD) begin
            hi = U16_HI;
            lo = (index == IDX_PERIOD) ? ONE : ZERO;
        end else if (index == IDX_DIRECTION || index == IDX_TRACKING) begin
            hi = SEL4_HI;
        end else if (index == IDX_HOLD) begin
            two_slot = 1'b1;
            lo = slot ? REACT_LO : HOLD_LO;
            hi = slot ? REACT_HI : U16_HI;
        end else if (index == IDX_OFFSET || (index >= IDX_THRESH_1 && index <= IDX_THRESH_8)) begin
            hi = LENGTH_HI;
        end else if (index == IDX_MINRATE) begin
            hi = MINRATE_HI;
        end else if (index == IDX_TRIGGER) begin
            hi = SEL5_HI;
        end else if (index == IDX_VMAX) begin
            lo = ONE;
            hi = VMAX_HI;
        end else if (index == IDX_VMIN) begin
            hi = VMIN_HI;
        end else if (index == IDX_WINDOW) begin
            lo = ONE;
            hi = WINDOW_HI;
        end else if (pulse_sign) begin
            two_slot = 1'b1;
            lo = slot ? ONE : ZERO;
            hi = slot ? SCALE_HI : ONE;
        end else if (index == IDX_LAYOUT) begin
            lo = ONE;
            hi = LAYOUT_HI;
        end else if (index == 6'h00 || index > IDX_LAST) begin
            known = 1'b0;
        end
    end

    // scaled integer compare, no fractions in hardware
    wire slot_ok = known && (two_slot || !slot);
    wire in_range = (value >= lo) && (value <= hi);
    assign ok = slot_ok && in_range;
    assign code = !slot_ok ? ERR_UNKNOWN : (in_range ? 16'h0000 : ERR_RANGE);
endmodule : fpc_param_check
`default_nettype wire

/* tb/fpc_master_model.sv */
// bus controller model: one complete startup parameter set per session
`timescale 1ns/1ps
`default_nettype none
module fpc_master_model (
    // clock and session request
    input wire logic sys_clk,
    input wire logic go,
    input wire logic [5:0] bad_index,
    input wire logic bad_slot,
    input wire logic [31:0] bad_value,
    input wire logic [31:0] period_value,
    // startup channel
    output logic bus_start,
    output logic startup_done,
    output logic param_valid,
    output logic [5:0] param_index,
    output logic param_slot,
    output logic [31:0] param_value,
    output logic busy
);
    function automatic logic [31:0] dflt(input int i, input logic s);
        case (i)
            1, 2: return 32'h14;
            4, 10: return 32'h2;
            5: return s ? 32'ha : 32'hfa;
            12: return 32'h190;
            14: return 32'h8;
            15, 18, 21: return s ? 32'ha : 32'h0;
            24: return 32'h6;
            default: return 32'h0;
        endcase
    endfunction : dflt

    task automatic session();
        busy = 1'b1;
        bus_start = 1'b1;
        @(negedge sys_clk);
        bus_start = 1'b0;
        for (int i = 1; i <= 36; i++) begin
            for (int s = 0; s < 2; s++) begin
                // a bad slot on a one-value parameter is sent too, to reach the unknown code
                if (s == 0 || i == 5 || i == 15 || i == 18 || i == 21 || (i == bad_index && s[0] == bad_slot)) begin
                    param_valid = 1'b1;
                    param_index = 6'(i);
                    param_slot = s[0];
                    param_value = (i == 25) ? period_value : dflt(i, s[0]);
                    if (param_index == bad_index && param_slot == bad_slot) param_value = bad_value;
                    @(negedge sys_clk);
                end
            end
        end
        param_valid = 1'b0;
        param_value = ~param_value;
        startup_done = 1'b1;
        @(negedge sys_clk);
        startup_done = 1'b0;
        busy = 1'b0;
    endtask : session

    initial begin
        logic start_req;
        {bus_start, startup_done, param_valid, param_slot, busy, param_index} = '0;
        param_value = 32'h5a5a_a5a5;
        forever begin
            // request taken at the rising edge, away from the bench's falling-edge changes
            @(posedge sys_clk);
            start_req = go;
            @(negedge sys_clk);
            // released data lines keep changing so stale values never match
            if (start_req) session();
            else param_value = ~param_value;
        end
    end
endmodule : fpc_master_model
`default_nettype wire

/* tb/tb_top.sv */
// self-checking bench of the fieldbus parameter and control block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import fpc_pkg::*;
    logic sys_clk = 0, reset = 1, go = 0, bad_slot = 0, local_wr = 0, local_slot = 0, cfg_slot = 0;
    logic error_detected = 0, signal_acquired = 0;
    logic bus_start, startup_done, param_valid, param_slot, busy, in_startup, resp_valid, param_rejected;
    logic standby, measure_direction, trigger_one, trigger_two, error_clear, restore_start, status_byte_valid;
    logic [5:0] bad_index = 0, local_index = 0, cfg_index = 0, param_index, resp_index;
    logic [31:0] bad_value = 0, period_value = 1, local_value = 0, speed_value = 0, length_value = 0;
    logic [31:0] param_value, cfg_value, velocity_magnitude, length_magnitude;
    logic [15:0] resp_code;
    logic [7:0] host_command_byte = 0, sensor_status_byte;
    logic [1:0] restore_set, rs = 0;
    logic [31:0] seed = 32'h04994ab6;
    int n_errors = 0, n_checks = 0, n_resp = 0, cycles = 0;
    logic [39:0] tbl [15] = '{{6'd1, 2'b01, 32'd100}, {6'd1, 2'b00, 32'd101}, {6'd5, 2'b00, 32'd9},
        {6'd5, 2'b11, 32'd65564}, {6'd5, 2'b10, 32'd65565}, {6'd6, 2'b01, 32'd9999999},
        {6'd6, 2'b00, 32'd10000000}, {6'd12, 2'b00, 32'd0}, {6'd13, 2'b01, 32'd1000000},
        {6'd15, 2'b10, 32'd25001}, {6'd15, 2'b11, 32'd1}, {6'd24, 2'b00, 32'd7},
        {6'd34, 2'b00, 32'd10000000}, {6'd3, 2'b00, 32'd2}, {6'd3, 2'b10, 32'd0}};

    fpc_top u_dut (.sys_clk, .reset, .bus_start, .startup_done, .in_startup, .param_valid, .param_index,
        .param_slot, .param_value, .resp_valid, .resp_index, .resp_code, .param_rejected, .local_wr,
        .local_index, .local_slot, .local_value, .cfg_index, .cfg_slot, .cfg_value, .host_command_byte,
        .standby, .measure_direction, .trigger_one, .trigger_two, .error_clear, .restore_start, .restore_set,
        .error_detected, .signal_acquired, .speed_value, .length_value, .sensor_status_byte,
        .status_byte_valid, .velocity_magnitude, .length_magnitude);
    fpc_master_model u_master (.sys_clk, .go, .bad_index, .bad_slot, .bad_value, .period_value, .bus_start,
        .startup_done, .param_valid, .param_index, .param_slot, .param_value, .busy);

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    function automatic logic [31:0] mag(input logic [31:0] x);
        return x[31] ? -x : x;
    endfunction : mag

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic read(input logic [5:0] i, input logic s, input logic [31:0] exp);
        @(negedge sys_clk);
        {cfg_index, cfg_slot} = {i, s};
        @(negedge sys_clk);
        check(cfg_value, exp);
    endtask : read

    task automatic lwrite(input logic [5:0] i, input logic [31:0] v);
        @(negedge sys_clk);
        {local_wr, local_index, local_value} = {1'b1, i, v};
        @(negedge sys_clk);
        local_wr = 1'b0;
    endtask : lwrite

    task automatic session(input logic [39:0] e);
        int r;
        logic [15:0] code;
        r = n_resp;
        code = (e[33] && !(e[39:34] inside {IDX_HOLD, IDX_PULSE_A, IDX_PULSE_B, IDX_PULSE_C})) ? ERR_UNKNOWN : ERR_RANGE;
        period_value = rnd() % 65535 + 1;
        @(negedge sys_clk);
        {bad_index, bad_slot, bad_value, go} = {e[39:33], e[31:0], 1'b1};
        @(negedge sys_clk);
        go = 1'b0;
        lwrite(6'd2, 32'h4d);
        check(in_startup, 1);
        while (busy) @(posedge sys_clk);
        repeat (2) @(negedge sys_clk);
        check(in_startup, 0);
        check(n_resp - r, !e[32]);
        check(param_rejected, !e[32]);
        if (!e[32]) check({resp_index, resp_code}, {e[39:34], code});
        else read(e[39:34], e[33], e[31:0]);
        read(6'd25, 0, (e[32] || e[39:34] > 25) ? period_value : 32'd30);
        read(6'd2, 0, 32'h14);
    endtask : session

    task automatic ctrl_run(input logic sel, input logic lay);
        logic [7:0] p, q;
        logic [33:0] st;
        q = host_command_byte;
        for (int k = 0; k < 200; k++) begin
            @(negedge sys_clk);
            if (k > 0) begin
                check(standby, sel ? q[0] : q[2]);
                check(trigger_two, sel & q[2]);
                check({measure_direction, trigger_one}, {q[1], q[3]});
                check({error_clear, restore_start}, {q[4] & ~p[4], q[7] & ~p[7]});
                if (q[7] & ~p[7]) rs = q[6:5];
                check(restore_set, rs);
                check(sensor_status_byte, {4'h0, length_value[31], speed_value[31], st[0], st[1]});
                check(velocity_magnitude, mag(speed_value));
                check(length_magnitude, mag(length_value));
                check(status_byte_valid, lay);
            end
            p = q;
            q = 8'(rnd());
            st = 34'(rnd());
            host_command_byte = q;
            {error_detected, signal_acquired} = st[1:0];
            speed_value = (k == 7) ? 32'hffff_ffff : rnd();
            length_value = rnd();
        end
    endtask : ctrl_run

    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : complete_run

    initial forever #5 sys_clk = ~sys_clk;

    // counted at the falling edge, where registered outputs have settled
    always @(negedge sys_clk) begin
        cycles++;
        if (resp_valid === 1'b1) n_resp++;
        if (cycles == 10000) begin
            n_errors++;
            complete_run();
        end
    end

    initial begin
        repeat (8) @(negedge sys_clk);
        reset = 0;
        check(in_startup, 0);
        read(6'd12, 0, 32'h190);
        lwrite(6'd2, 32'd50);
        read(6'd2, 0, 32'd50);
        $display("test reset and local done");
        foreach (tbl[i]) session(tbl[i]);
        $display("test startup ranges done");
        ctrl_run(0, 1);
        lwrite(6'd9, 1);
        lwrite(6'd24, 3);
        ctrl_run(1, 0);
        $display("test control and status done");
        complete_run();
    end
endmodule : tb_top
`default_nettype wire
